// [rtl/lddma_core.sv]
// Legacy two-controller DMA with distributed register redirection.
// Assumes a PCI target front end that turns bus phases into the start/irdy
// strobes below, and an initiator that runs one byte I/O cycle per request.
`timescale 1ns/1ns
module lddma_core
   import lddma_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Target side of legacy I/O cycles
   input wire logic tgt_start_in,
   input wire logic [15:0] tgt_addr_in,
   input wire logic tgt_wr_in,
   input wire logic [3:0] tgt_be_in,
   input wire logic [31:0] tgt_wdata_in,
   input wire logic tgt_host_in,
   input wire logic tgt_irdy_in,
   output logic tgt_devsel_n_out,
   output logic tgt_stop_n_out,
   output logic tgt_trdy_n_out,
   output logic [31:0] tgt_rdata_out,
   // Bus arbitration and byte initiator
   output logic bus_req_out,
   input wire logic bus_gnt_in,
   output logic host_req_mask_out,
   output logic init_valid_out,
   output logic [15:0] init_addr_out,
   output logic init_wr_out,
   output logic [7:0] init_wdata_out,
   input wire logic init_done_in,
   input wire logic [7:0] init_rdata_in,
   // Configuration space
   input wire logic cfg_wr_in,
   input wire logic cfg_rd_in,
   input wire logic [7:0] cfg_addr_in,
   input wire logic [3:0] cfg_be_in,
   input wire logic [31:0] cfg_wdata_in,
   output logic [31:0] cfg_rdata_out,
   input wire logic slave_sel_wr_in,
   input wire logic [7:0] slave_sel_in,
   output logic [7:0] chan_sel_out,
   // DMA channels and memory address stream
   input wire logic [7:0] dreq_in,
   output logic [7:0] dack_out,
   input wire logic cnt_load_in,
   input wire logic [2:0] cnt_chan_in,
   input wire logic [15:0] cnt_value_in,
   output logic mem_valid_out,
   input wire logic mem_ready_in,
   output logic [23:0] mem_addr_out,
   output logic mem_word_out,
   output logic tc_out
);

   typedef struct packed {
      lddma_st_t st;
      logic direct;
      logic done_flag;
      logic [15:0] paddr;
      logic pwr;
      logic [31:0] pwdata;
      logic [3:0] rem;
      logic [31:0] coll;
      logic page_hit;
      logic [2:0] pslot;
      logic [2:0] chan;
      logic devsel_n;
      logic stop_n;
      logic trdy_n;
      logic [31:0] trdata;
      logic req;
      logic hmask;
      logic [1:0] lane;
      logic [15:0] iaddr;
      logic iwr;
      logic [7:0] idata;
      logic en;
      logic [7:0] sel;
      logic [8:0] base;
      logic [31:0] crdata;
      logic [7:0][7:0] page;
      logic [7:0][15:0] cnt;
      logic [4:0] tick;
      logic [7:0] dack;
      logic tc;
      logic [1:0][24:0] fifo;
      logic wp;
      logic rp;
      logic [1:0] fcnt;
   } lddma_state_t;

   lddma_state_t s_r;
   lddma_state_t s_nxt;

   // {hit, slot} for a page port
   function automatic logic [3:0] page_slot(input logic [15:0] a);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if (a == LDDMA_PAGE_PORT[i]) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   // {hit, channel} for a controller register
   function automatic logic [3:0] legacy_chan(input logic [15:0] a);
      logic [3:0] r;
      r = 4'h0;
      if (a >= LDDMA_C1_LO && a <= LDDMA_C1_HI) begin
         r = {1'b1, 1'b0, a[3] ? 2'h0 : a[2:1]};
      end else if (a >= LDDMA_C2_LO && a <= LDDMA_C2_HI) begin
         r = {1'b1, 1'b1, a[4] ? 2'h0 : a[3:2]};
      end
      return r;
   endfunction

   function automatic logic [1:0] low_lane(input logic [3:0] m);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   logic [3:0] pg_dec;
   logic [3:0] lg_dec;
   logic [1:0] nl;
   logic [3:0] rem_next;
   logic [2:0] win;
   logic win_ok;
   logic [7:0] pgv;
   logic [15:0] cv;

   assign pg_dec = page_slot(tgt_addr_in);
   assign lg_dec = legacy_chan(tgt_addr_in);

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      nl = 2'h0;
      rem_next = 4'h0;
      win = 3'h0;
      win_ok = 1'b0;
      pgv = 8'h00;
      cv = 16'h0000;
      s_nxt.stop_n = 1'b1;
      s_nxt.trdy_n = 1'b1;
      s_nxt.dack = 8'h00;
      s_nxt.tc = 1'b0;

      // Target cycle sequencing
      case (s_r.st)
         LDDMA_IDLE: begin
            if (tgt_start_in && pg_dec[3]) begin
               s_nxt.devsel_n = 1'b0;
               s_nxt.page_hit = 1'b1;
               s_nxt.pslot = pg_dec[2:0];
               s_nxt.paddr = tgt_addr_in;
               s_nxt.pwr = tgt_wr_in;
               s_nxt.st = LDDMA_DONE;
            end else if (tgt_start_in && lg_dec[3] && s_r.en) begin
               s_nxt.devsel_n = 1'b0;
               s_nxt.page_hit = 1'b0;
               s_nxt.paddr = tgt_addr_in;
               s_nxt.pwr = tgt_wr_in;
               s_nxt.rem = tgt_be_in;
               s_nxt.chan = lg_dec[2:0];
               s_nxt.direct = !tgt_host_in;
               if (s_r.sel[lg_dec[2:0]] || lg_dec[2:0] == LDDMA_CASCADE_CH) begin
                  s_nxt.coll = 32'h0000_0000;
                  s_nxt.st = LDDMA_DONE;
               end else if (!tgt_host_in) begin
                  s_nxt.st = LDDMA_REQ;
                  s_nxt.req = 1'b1;
               end else if (s_r.done_flag) begin
                  s_nxt.st = LDDMA_DONE;
               end else begin
                  s_nxt.st = LDDMA_CLAIM;
               end
            end
         end
         LDDMA_CLAIM: begin
            if (tgt_irdy_in) begin
               s_nxt.stop_n = 1'b0;
               s_nxt.devsel_n = 1'b1;
               s_nxt.req = 1'b1;
               s_nxt.hmask = 1'b1;
               s_nxt.pwdata = tgt_wdata_in;
               s_nxt.st = LDDMA_REQ;
            end
         end
         LDDMA_REQ: begin
            if (s_r.direct && tgt_irdy_in) begin
               s_nxt.pwdata = tgt_wdata_in;
            end
            if (bus_gnt_in && (!s_r.direct || tgt_irdy_in)) begin
               nl = low_lane(s_r.rem);
               s_nxt.lane = nl;
               s_nxt.iaddr = {s_r.base, s_r.chan, s_r.paddr[3:2], nl};
               s_nxt.iwr = s_r.pwr;
               s_nxt.idata = s_r.direct ? tgt_wdata_in[8 * nl +: 8] : s_r.pwdata[8 * nl +: 8];
               s_nxt.coll = 32'h0000_0000;
               s_nxt.st = LDDMA_RUN;
            end
         end
         LDDMA_RUN: begin
            if (s_r.rem == 4'h0) begin
               s_nxt.req = 1'b0;
               if (s_r.direct) begin
                  s_nxt.st = LDDMA_DONE;
               end else begin
                  s_nxt.done_flag = 1'b1;
                  s_nxt.hmask = 1'b0;
                  s_nxt.st = LDDMA_IDLE;
               end
            end else if (init_done_in) begin
               s_nxt.coll[8 * s_r.lane +: 8] = init_rdata_in;
               rem_next = s_r.rem & ~(4'h1 << s_r.lane);
               s_nxt.rem = rem_next;
               nl = low_lane(rem_next);
               s_nxt.lane = nl;
               s_nxt.iaddr = {s_r.base, s_r.chan, s_r.paddr[3:2], nl};
               s_nxt.idata = s_r.pwdata[8 * nl +: 8];
            end
         end
         LDDMA_DONE: begin
            if (tgt_irdy_in) begin
               s_nxt.trdy_n = 1'b0;
               s_nxt.devsel_n = 1'b1;
               s_nxt.st = LDDMA_IDLE;
               if (s_r.page_hit) begin
                  s_nxt.trdata = {4{s_r.page[s_r.pslot]}};
                  if (s_r.pwr) begin
                     s_nxt.page[s_r.pslot] = tgt_wdata_in[8 * s_r.paddr[1:0] +: 8];
                  end
               end else begin
                  s_nxt.trdata = s_r.coll;
                  if (!s_r.direct) begin
                     s_nxt.done_flag = 1'b0;
                  end
               end
            end
         end
         default: begin
            s_nxt.st = LDDMA_IDLE;
         end
      endcase

      ////////////////////////////////////////////////////////////////////
      // Configuration access
      if (cfg_rd_in) begin
         if (cfg_addr_in == LDDMA_CFG_MCFG) begin
            s_nxt.crdata = {s_r.en, 23'h000000, s_r.sel};
         end else if (cfg_addr_in == LDDMA_CFG_BASE) begin
            s_nxt.crdata = {16'h0000, s_r.base, 7'h00};
         end else begin
            s_nxt.crdata = 32'h0000_0000;
         end
      end
      if (slave_sel_wr_in) begin
         s_nxt.sel = slave_sel_in & LDDMA_SEL_MASK;
      end
      if (cfg_wr_in && cfg_addr_in == LDDMA_CFG_MCFG) begin
         if (cfg_be_in[3]) begin
            s_nxt.en = cfg_wdata_in[LDDMA_MCFG_EN_BIT];
         end
         if (cfg_be_in[0]) begin
            s_nxt.sel = cfg_wdata_in[7:0] & LDDMA_SEL_MASK;
         end
      end
      if (cfg_wr_in && cfg_addr_in == LDDMA_CFG_BASE) begin
         if (cfg_be_in[0]) begin
            s_nxt.base[0] = cfg_wdata_in[LDDMA_BASE_LSB];
         end
         if (cfg_be_in[1]) begin
            s_nxt.base[8:1] = cfg_wdata_in[15:8];
         end
      end

      ////////////////////////////////////////////////////////////////////
      // Channel service at the controller rate
      if (cnt_load_in) begin
         s_nxt.cnt[cnt_chan_in] = cnt_value_in;
      end
      s_nxt.tick = (s_r.tick == LDDMA_TICK_LAST) ? 5'h00 : s_r.tick + 5'h01;
      // Lowest number wins, so 0..3 beat 5..7; 4 is skipped
      for (int i = 7; i >= 0; i--) begin
         if (dreq_in[i] && 3'(i) != LDDMA_CASCADE_CH) begin
            win = 3'(i);
            win_ok = 1'b1;
         end
      end
      // Stall on a full buffer keeps the request pending, not dropped
      if (s_r.tick == LDDMA_TICK_LAST && win_ok && s_r.fcnt != 2'h2) begin
         pgv = s_r.page[win];
         cv = s_r.cnt[win];
         s_nxt.dack[win] = 1'b1;
         if (win[2]) begin
            s_nxt.fifo[s_r.wp] = {1'b1, pgv[7:1], cv, 1'b0};
         end else begin
            s_nxt.fifo[s_r.wp] = {1'b0, pgv, cv};
         end
         // Counter wraps in 16 bits; page is never carried into
         s_nxt.cnt[win] = cv + 16'h0001;
         s_nxt.tc = (cv == LDDMA_CNT_LAST);
         s_nxt.wp = !s_r.wp;
      end
      if (s_r.fcnt != 2'h0 && mem_ready_in) begin
         s_nxt.rp = !s_r.rp;
      end
      s_nxt.fcnt = s_r.fcnt + 2'(s_nxt.wp != s_r.wp) - 2'(s_nxt.rp != s_r.rp);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_r <= '0;
         s_r.st <= LDDMA_IDLE;
         s_r.devsel_n <= 1'b1;
         s_r.stop_n <= 1'b1;
         s_r.trdy_n <= 1'b1;
         s_r.en <= LDDMA_MCFG_RST[LDDMA_MCFG_EN_BIT];
         s_r.sel <= LDDMA_SEL_RST;
         s_r.base <= LDDMA_BASE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign tgt_devsel_n_out = s_r.devsel_n;
   assign tgt_stop_n_out = s_r.stop_n;
   assign tgt_trdy_n_out = s_r.trdy_n;
   assign tgt_rdata_out = s_r.trdata;
   assign bus_req_out = s_r.req;
   assign host_req_mask_out = s_r.hmask;
   assign init_valid_out = (s_r.st == LDDMA_RUN) && (s_r.rem != 4'h0);
   assign init_addr_out = s_r.iaddr;
   assign init_wr_out = s_r.iwr;
   assign init_wdata_out = s_r.idata;
   assign cfg_rdata_out = s_r.crdata;
   assign chan_sel_out = s_r.sel;
   assign dack_out = s_r.dack;
   assign tc_out = s_r.tc;
   assign mem_valid_out = (s_r.fcnt != 2'h0);
   assign mem_word_out = s_r.fifo[s_r.rp][24];
   assign mem_addr_out = s_r.fifo[s_r.rp][23:0];

endmodule

// [shared/lddma_pkg.sv]
// Constants, states and decode tables of the legacy distributed DMA block.
// Assumes byte-addressed 16-bit I/O decode and 8-bit config offsets.
package lddma_pkg;
   // Config space offsets
   localparam logic [7:0] LDDMA_CFG_MCFG = 8'h8C;
   localparam logic [7:0] LDDMA_CFG_BASE = 8'h90;
   localparam logic [31:0] LDDMA_MCFG_RST = 32'h0000_0000;
   localparam int LDDMA_MCFG_EN_BIT = 31;
   localparam logic [7:0] LDDMA_SEL_MASK = 8'hEF;
   localparam logic [7:0] LDDMA_SEL_RST = 8'h00;
   localparam int LDDMA_BASE_LSB = 7;
   localparam logic [8:0] LDDMA_BASE_RST = 9'h010;
   // Legacy register decode
   localparam logic [15:0] LDDMA_C1_LO = 16'h0000;
   localparam logic [15:0] LDDMA_C1_HI = 16'h000F;
   localparam logic [15:0] LDDMA_C2_LO = 16'h00C0;
   localparam logic [15:0] LDDMA_C2_HI = 16'h00DF;
   localparam logic [2:0] LDDMA_CASCADE_CH = 3'h4;
   localparam logic [2:0] LDDMA_REFRESH_SLOT = 3'h4;
   // Page ports by slot: 0,1,2,3, refresh, 5,6,7
   localparam logic [7:0][15:0] LDDMA_PAGE_PORT = {
      16'h008A, 16'h0089, 16'h008B, 16'h008F,
      16'h0082, 16'h0081, 16'h0083, 16'h0087};
   localparam logic [15:0] LDDMA_CNT_LAST = 16'hFFFF;
   // Controller sequencing rate
   localparam int LDDMA_CLK_NS = 4;
   localparam int LDDMA_DMA_NS = 125;
   localparam int LDDMA_TICK_CYC = LDDMA_DMA_NS / LDDMA_CLK_NS;
   localparam logic [4:0] LDDMA_TICK_LAST = 5'(LDDMA_TICK_CYC - 1);

   typedef enum logic [2:0] {
      LDDMA_IDLE = 3'b000,
      LDDMA_CLAIM = 3'b001,
      LDDMA_REQ = 3'b010,
      LDDMA_RUN = 3'b011,
      LDDMA_DONE = 3'b100
   } lddma_st_t;
endpackage

// [sim/lddma_core_assertions.sv]
// Port checker for the legacy DMA core.
// Assumes a bind onto lddma_core; sees its ports only.
`timescale 1ns/1ns
module lddma_core_assertions
   import lddma_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic tgt_start_in,
   input wire logic tgt_irdy_in,
   input wire logic tgt_devsel_n_out,
   input wire logic tgt_stop_n_out,
   input wire logic bus_req_out,
   input wire logic host_req_mask_out,
   input wire logic init_valid_out,
   input wire logic [15:0] init_addr_out,
   input wire logic init_done_in,
   input wire logic [7:0] dreq_in,
   input wire logic [7:0] dack_out,
   input wire logic mem_valid_out,
   input wire logic mem_ready_in,
   input wire logic [23:0] mem_addr_out,
   input wire logic mem_word_out,
   input wire logic tc_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////////////////
   AST_CLAIM: assert property ($fell(tgt_devsel_n_out) |-> $past(tgt_start_in))
      else $error("claim without start");
   AST_RETRY: assert property (!tgt_stop_n_out |->
      bus_req_out && host_req_mask_out && tgt_devsel_n_out && $past(tgt_irdy_in))
      else $error("retry without request");
   AST_MASK: assert property ($fell(tgt_stop_n_out) |=> host_req_mask_out [*2])
      else $error("host mask dropped early");
   AST_INIT_HOLD: assert property (init_valid_out && !init_done_in |=>
      init_valid_out && $stable(init_addr_out))
      else $error("byte cycle not held");
   AST_INIT_BUS: assert property (init_valid_out |-> bus_req_out)
      else $error("byte cycle without bus");
   AST_UNMASK: assert property ($fell(host_req_mask_out) |-> !bus_req_out && !init_valid_out)
      else $error("unmask before release");
   AST_CASCADE: assert property (dack_out != 8'h00 |-> $onehot(dack_out) && !dack_out[4])
      else $error("bad acknowledge");
   AST_PRIO: assert property (dack_out[7:5] != 3'h0 |-> $past(dreq_in[3:0]) == 4'h0)
      else $error("word channel beat byte channel");
   AST_TICK: assert property (dack_out != 8'h00 |=> (dack_out == 8'h00) [*8])
      else $error("service too fast");
   AST_EVEN: assert property (mem_valid_out && mem_word_out |-> !mem_addr_out[0])
      else $error("odd word address");
   AST_HOLD: assert property (mem_valid_out && !mem_ready_in |=>
      mem_valid_out && $stable({mem_addr_out, mem_word_out}))
      else $error("stalled entry lost");
   C_RETRY: cover property (!tgt_stop_n_out);
   C_TC: cover property (tc_out);
   C_STALL: cover property (mem_valid_out && !mem_ready_in);
endmodule
bind lddma_core lddma_core_assertions u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
   .tgt_start_in(tgt_start_in), .tgt_irdy_in(tgt_irdy_in),
   .tgt_devsel_n_out(tgt_devsel_n_out), .tgt_stop_n_out(tgt_stop_n_out),
   .bus_req_out(bus_req_out), .host_req_mask_out(host_req_mask_out),
   .init_valid_out(init_valid_out), .init_addr_out(init_addr_out),
   .init_done_in(init_done_in), .dreq_in(dreq_in), .dack_out(dack_out),
   .mem_valid_out(mem_valid_out), .mem_ready_in(mem_ready_in),
   .mem_addr_out(mem_addr_out), .mem_word_out(mem_word_out), .tc_out(tc_out));

// [sim/lddma_partner.sv]
// Far side: bus arbiter plus the target that finishes byte I/O cycles.
// Assumes the core is the only requester; the bench plays the host bridge.
`timescale 1ns/1ns
module lddma_partner (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic bus_req_in,
   input wire logic init_valid_in,
   input wire logic [15:0] init_addr_in,
   input wire logic slow_in,
   output logic bus_gnt_out,
   output logic init_done_out,
   output logic [7:0] init_rdata_out
);
   logic [2:0] wait_r;
   logic [7:0] junk_r;
   // Released data lines change every cycle so a late sample cannot match
   assign init_rdata_out = init_done_out ? (init_addr_in[7:0] ^ 8'hA5) : junk_r;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         bus_gnt_out <= 1'b0;
         init_done_out <= 1'b0;
         wait_r <= 3'h0;
         junk_r <= 8'h00;
      end else begin
         junk_r <= junk_r + 8'h3B;
         // Host request is masked, so the core is granted one cycle after it requests
         bus_gnt_out <= bus_req_in;
         init_done_out <= 1'b0;
         if (init_valid_in && bus_gnt_out && !init_done_out) begin
            if (wait_r >= (slow_in ? 3'h4 : 3'h0)) begin
               init_done_out <= 1'b1;
               wait_r <= 3'h0;
            end else begin
               wait_r <= wait_r + 3'h1;
            end
         end
      end
   end
endmodule

// [sim/tb_legacy_distributed_dma.sv]
// Self-checking bench for the legacy DMA core.
// Assumes lddma_partner answers arbitration and byte cycles.
`timescale 1ns/1ns
module tb_legacy_distributed_dma;
   import lddma_pkg::*;
   logic clk_sys_in = 0, rst_in = 1, tgt_start_in = 0, tgt_wr_in = 0, tgt_host_in = 0;
   logic tgt_irdy_in = 0, cfg_wr_in = 0, cfg_rd_in = 0, slave_sel_wr_in = 0, cnt_load_in = 0;
   logic mem_ready_in = 0, slow = 0;
   logic [15:0] tgt_addr_in = 16'h0000, cnt_value_in = 16'h0000, seed = 16'h002A;
   logic [3:0] tgt_be_in = 4'h0, cfg_be_in = 4'hF;
   logic [31:0] tgt_wdata_in = 32'h0, cfg_wdata_in = 32'h0;
   logic [7:0] cfg_addr_in = 8'h00, slave_sel_in = 8'h00, dreq_in = 8'h00;
   logic [2:0] cnt_chan_in = 3'h0;
   logic tgt_devsel_n_out, tgt_stop_n_out, tgt_trdy_n_out, bus_req_out, bus_gnt_in;
   logic host_req_mask_out, init_valid_out, init_wr_out, init_done_in;
   logic mem_valid_out, mem_word_out, tc_out;
   logic [31:0] tgt_rdata_out, cfg_rdata_out;
   logic [15:0] init_addr_out;
   logic [7:0] init_wdata_out, init_rdata_in, chan_sel_out, dack_out;
   logic [23:0] mem_addr_out;
   logic [7:0] page[8];
   logic [15:0] cnt[8];
   logic [15:0] pp[8] = '{16'h0087, 16'h0083, 16'h0081, 16'h0082,
      16'h008F, 16'h008B, 16'h0089, 16'h008A};
   logic [15:0] ia[$];
   logic [7:0] id[$];
   logic [24:0] mq[$];
   int miscompares = 0, num_checks = 0, cyc = 0, c, code;
   lddma_core uut (.*);
   lddma_partner u_far (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_req_in(bus_req_out),
      .init_valid_in(init_valid_out), .init_addr_in(init_addr_out), .slow_in(slow),
      .bus_gnt_out(bus_gnt_in), .init_done_out(init_done_in), .init_rdata_out(init_rdata_in));
   always #2 clk_sys_in = ~clk_sys_in;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task end_of_test;
      if (miscompares == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   // Result: 0 completed, 1 retried, 2 never answered
   task automatic acc(input logic [15:0] a, input logic w, input logic [3:0] be,
      input logic [31:0] d, input logic h, output int r);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      tgt_start_in <= 1;
      tgt_addr_in <= a;
      tgt_wr_in <= w;
      tgt_be_in <= be;
      tgt_wdata_in <= d;
      tgt_host_in <= h;
      tgt_irdy_in <= 1;
      @(posedge clk_sys_in);
      tgt_start_in <= 0;
      while (tgt_trdy_n_out !== 1'b0 && tgt_stop_n_out !== 1'b0 && n < 60) begin
         @(posedge clk_sys_in);
         n++;
      end
      r = (tgt_trdy_n_out === 1'b0) ? 0 : (tgt_stop_n_out === 1'b0) ? 1 : 2;
      tgt_irdy_in <= 0;
   endtask
   task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      cfg_wr_in <= w;
      cfg_rd_in <= !w;
      cfg_addr_in <= a;
      cfg_wdata_in <= d;
      @(posedge clk_sys_in);
      cfg_wr_in <= 0;
      cfg_rd_in <= 0;
      @(posedge clk_sys_in);
   endtask
   // Legacy access redistributed as byte cycles starting at address p
   task automatic hop(input logic [15:0] a, input logic w, input logic [3:0] be,
      input logic h, input logic [15:0] p);
      int n;
      logic [31:0] d, e, m;
      d = {seed, lfsr(seed)};
      seed = lfsr(lfsr(seed));
      e = 0;
      m = 0;
      n = 0;
      ia.delete();
      id.delete();
      slow <= seed[2];
      acc(a, w, be, d, h, code);
      ck(code, h);
      while (h && host_req_mask_out !== 1'b0 && n < 80) begin
         @(posedge clk_sys_in);
         n++;
      end
      if (h) ck(bus_req_out, 0);
      for (int l = 0; l < 4; l++) if (be[l]) begin
         ck(ia.pop_front(), p | l);
         m[8*l +: 8] = 8'hFF;
         e[8*l +: 8] = id.pop_front();
         if (w) ck(e[8*l +: 8], d[8*l +: 8]);
      end
      ck(ia.size(), 0);
      if (h) begin
         acc(a, w, be, d, h, code);
         ck(code, 0);
      end
      if (!w) ck(tgt_rdata_out & m, e);
   endtask
   task automatic ld(input int ch, input logic [15:0] v);
      @(posedge clk_sys_in);
      cnt_load_in <= 1;
      cnt_chan_in <= 3'(ch);
      cnt_value_in <= v;
      cnt[ch] = v;
      @(posedge clk_sys_in);
      cnt_load_in <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys_in) begin
      cyc++;
      if (init_valid_out && init_done_in) begin
         ia.push_back(init_addr_out);
         id.push_back(init_wr_out ? init_wdata_out : init_rdata_in);
      end
      if (dack_out !== 8'h00) begin
         c = 8;
         for (int i = 7; i >= 0; i--) if (dreq_in[i] && i != 4) c = i;
         ck(dack_out, 8'h01 << c);
         ck(tc_out, cnt[c] == 16'hFFFF);
         mq.push_back(c < 4 ? {1'b0, page[c], cnt[c]} : {1'b1, page[c][7:1], cnt[c], 1'b0});
         cnt[c]++;
      end
      if (mem_valid_out && mem_ready_in) ck({mem_word_out, mem_addr_out}, mq.pop_front());
      if (cyc > 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      tick(10);
      rst_in <= 0;
      cfg(0, 8'h8C, 0);
      ck(cfg_rdata_out, 0);
      cfg(0, 8'h90, 0);
      ck(cfg_rdata_out, 32'h0000_0800);
      for (int i = 0; i < 8; i++) begin
         page[i] = (i == 4) ? 8'h00 : seed[7:0];
         seed = lfsr(seed);
         acc(pp[i], 1, 4'h1 << pp[i][1:0], {4{page[i]}}, 1, code);
      end
      for (int i = 0; i < 8; i++) begin
         acc(pp[i], 0, 4'hF, 0, 1, code);
         ck(tgt_rdata_out, {4{page[i]}});
      end
      acc(16'h0084, 0, 4'h1, 0, 0, code);
      ck(code, 2);
      acc(16'h0002, 0, 4'h1, 0, 1, code);
      ck(code, 2);
      cfg(1, 8'h8C, 32'hFFFF_FFFF);
      cfg(0, 8'h8C, 0);
      ck(cfg_rdata_out, 32'h8000_00EF);
      ck(chan_sel_out, 8'hEF);
      @(posedge clk_sys_in);
      slave_sel_wr_in <= 1;
      slave_sel_in <= 8'h12;
      @(posedge clk_sys_in);
      slave_sel_wr_in <= 0;
      cfg(0, 8'h8C, 0);
      ck(cfg_rdata_out, 32'h8000_0002);
      ck(chan_sel_out, 8'h02);
      ia.delete();
      acc(16'h0002, 0, 4'h1, 0, 1, code);
      ck(code, 0);
      ck(tgt_rdata_out, 0);
      ck(ia.size(), 0);
      // Only this bridge owns the channels; no second bridge is modelled
      cfg(1, 8'h8C, 32'h8000_0000);
      hop(16'h0002, 0, 4'h1, 1, 16'h0810);
      hop(16'h0004, 1, 4'hF, 1, 16'h0824);
      hop(16'h00C4, 0, 4'h3, 0, 16'h0854);
      cfg(1, 8'h90, 32'h0000_0180);
      hop(16'h0006, 0, 4'hC, 1, 16'h01B4);
      ld(0, 16'hFFFF);
      ld(5, seed);
      dreq_in <= 8'h31;
      tick(150);
      ck(mq.size(), 2);
      dreq_in <= 8'h30;
      tick(3);
      repeat (300) begin
         @(posedge clk_sys_in);
         mem_ready_in <= seed[0];
         seed = lfsr(seed);
      end
      while (dack_out === 8'h00) @(posedge clk_sys_in);
      dreq_in <= 8'h00;
      mem_ready_in <= 1;
      tick(40);
      ck(mq.size(), 0);
      ck(mem_valid_out, 0);
      end_of_test();
   end
endmodule
